// >>> include/smpm_pkg.sv
// Purpose: shared constants and types of the serial radio packet modem
// Assumes: one 250 MHz clock, asynchronous active-low reset
// Notes: radio bits go MSB first, host UART bits LSB first
package smpm_pkg;
   // ==========================================
   // Timing
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned HOST_BAUD = 19_200;
   localparam int unsigned UART_BIT_CYC = CLK_HZ / HOST_BAUD;
   localparam int unsigned RF_BIT_RATE = 34_500;
   localparam int unsigned RF_BIT_CYC = CLK_HZ / RF_BIT_RATE;
   localparam int unsigned TX_STARTUP_US = 4_000;
   localparam int unsigned TX_STARTUP_CYC = (CLK_HZ / 1_000_000) * TX_STARTUP_US;
   // ==========================================
   // Buffers and framing
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned SKID_DEPTH = 2;
   localparam int unsigned PAYLOAD_BYTES = 6;
   localparam logic [2:0] PAY_LAST = 3'(PAYLOAD_BYTES - 1);
   localparam logic [2:0] CSUM_IDX = 3'(PAYLOAD_BYTES);
   localparam logic [2:0] PRE_LAST = 3'h2;
   localparam logic [7:0] PREAMBLE_CODE = 8'h55;
   localparam logic [7:0] SYNC_CODE = 8'hb4;
   localparam logic [7:0] IDLE_CODE = 8'h00;
   localparam logic [3:0] FRAME_BITS = 4'ha;
   localparam logic LINE_IDLE = 1'b1;
   // ==========================================
   // States
   typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} smpm_urx_t;
   typedef enum logic [2:0] {T_OFF, T_WARM, T_PRE, T_SYNC, T_PAY, T_SUM} smpm_txst_t;
   typedef enum logic [1:0] {R_HUNT, R_COLLECT, R_PUSH} smpm_rxst_t;
endpackage

// >>> include/smpm_if.sv
// Purpose: host-side pins between host and modem
// Assumes: status pin is open drain with a pull-up
// Notes: drivers only ever pull low
`timescale 1ns/1ps
interface smpm_if;
   logic txd;
   logic rxd;
   logic status_dev_o;
   logic status_dev_oe_n;
   logic status_host_o;
   logic status_host_oe_n;
   logic status_level;
   // Wired-AND with pull-up: low when any end enables its driver
   assign status_level = status_dev_oe_n & status_host_oe_n;
   modport device(input txd, input status_level, output rxd, output status_dev_o,
                  output status_dev_oe_n);
   modport host(output txd, output status_host_o, output status_host_oe_n,
                input rxd, input status_level);
endinterface

// >>> core/smpm_device.sv
// Purpose: modem end: host UART, packet framer, radio bit serializer
// Assumes: radio front end takes and gives NRZ bits, key high = on
// Notes: also holds FIFO and UART leaves reused by the host end
`timescale 1ns/1ps
// ==========================================
// FIFO
module smpm_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = smpm_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Fill side
   input wire logic [W-1:0] wdata_i,
   input wire logic wvalid_i,
   output logic wready_o,
   // Drain side
   output logic [W-1:0] rdata_o,
   output logic rvalid_o,
   input wire logic rready_i
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q, rptr_q;
   logic [AW:0] cnt_q;
   logic push, pop;
   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction
   assign wready_o = cnt_q != (AW+1)'(DEPTH);
   assign rvalid_o = cnt_q != '0;
   assign rdata_o = mem_q[rptr_q];
   assign push = wvalid_i && wready_o;
   assign pop = rready_i && rvalid_o;
   // Storage, no reset needed for data
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wptr_q] <= wdata_i;
      end
   end
   // Pointers and fill count
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= next_ptr(wptr_q);
         end
         if (pop) begin
            rptr_q <= next_ptr(rptr_q);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==========================================
// UART receiver
module smpm_uart_rx #(
   parameter int unsigned BIT_CYC = smpm_pkg::UART_BIT_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Serial line from another domain
   input wire logic line_i,
   // Received character
   output logic [7:0] data_o,
   output logic valid_o
);
   logic meta_q, line_q;
   smpm_pkg::smpm_urx_t st_q;
   logic [31:0] cnt_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   // Two-flop synchroniser, idle high
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q <= smpm_pkg::LINE_IDLE;
         line_q <= smpm_pkg::LINE_IDLE;
      end else begin
         meta_q <= line_i;
         line_q <= meta_q;
      end
   end
   // Start, eight data bits LSB first, stop; no parity
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_q <= smpm_pkg::U_IDLE;
         cnt_q <= '0;
         bit_q <= '0;
         sh_q <= '0;
         data_o <= '0;
         valid_o <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         case (st_q)
            smpm_pkg::U_IDLE: if (!line_q) begin
               st_q <= smpm_pkg::U_START;
               cnt_q <= BIT_CYC / 2;
            end
            smpm_pkg::U_START: if (cnt_q != 0) begin
               cnt_q <= cnt_q - 1;
            end else if (!line_q) begin
               st_q <= smpm_pkg::U_DATA;
               cnt_q <= BIT_CYC - 1;
               bit_q <= '0;
            end else begin
               st_q <= smpm_pkg::U_IDLE; // Glitch, not a start bit
            end
            smpm_pkg::U_DATA: if (cnt_q != 0) begin
               cnt_q <= cnt_q - 1;
            end else begin
               sh_q <= {line_q, sh_q[7:1]};
               cnt_q <= BIT_CYC - 1;
               bit_q <= bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  st_q <= smpm_pkg::U_STOP;
               end
            end
            smpm_pkg::U_STOP: if (cnt_q != 0) begin
               cnt_q <= cnt_q - 1;
            end else begin
               // Framing error drops the character silently
               if (line_q) begin
                  valid_o <= 1'b1;
                  data_o <= sh_q;
               end
               st_q <= smpm_pkg::U_IDLE;
            end
            default: st_q <= smpm_pkg::U_IDLE;
         endcase
      end
   end
endmodule

// ==========================================
// UART transmitter
module smpm_uart_tx #(
   parameter int unsigned BIT_CYC = smpm_pkg::UART_BIT_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Character in
   input wire logic [7:0] data_i,
   input wire logic valid_i,
   output logic ready_o,
   // Serial line
   output logic line_o
);
   logic [9:0] sh_q;
   logic [3:0] n_q;
   logic [31:0] cnt_q;
   assign ready_o = n_q == 4'h0;
   assign line_o = sh_q[0];
   // Frame shifter, fills with ones so the line rests high
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sh_q <= 10'h3ff;
         n_q <= '0;
         cnt_q <= '0;
      end else if (n_q == 4'h0) begin
         if (valid_i) begin
            sh_q <= {1'b1, data_i, 1'b0};
            n_q <= smpm_pkg::FRAME_BITS;
            cnt_q <= BIT_CYC - 1;
         end
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end else begin
         cnt_q <= BIT_CYC - 1;
         sh_q <= {1'b1, sh_q[9:1]};
         n_q <= n_q - 4'h1;
      end
   end
endmodule

// ==========================================
// Modem end
module smpm_device #(
   parameter int unsigned UART_BIT_CYC = smpm_pkg::UART_BIT_CYC,
   parameter int unsigned RF_BIT_CYC = smpm_pkg::RF_BIT_CYC,
   parameter int unsigned STARTUP_CYC = smpm_pkg::TX_STARTUP_CYC,
   parameter int unsigned FIFO_DEPTH = smpm_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Host pins
   smpm_if.device link,
   // Radio front end
   output logic rf_tx_data_o,
   output logic rf_tx_key_o,
   input wire logic rf_rx_data_i,
   // Mode
   output logic standby_o
);
   logic [7:0] hrx_data, txf_rdata, rxf_rdata, pay_byte, rx_bits, rx_sum_q;
   logic hrx_valid, txf_rvalid, txf_pop, rxf_wvalid, rxf_rvalid, utx_ready;
   smpm_pkg::smpm_txst_t tx_st_q;
   smpm_pkg::smpm_rxst_t rx_st_q;
   logic [31:0] tx_cnt_q, rx_cnt_q;
   logic [7:0] tx_sh_q, rx_sh_q, tx_sum_q;
   logic [2:0] tx_bit_q, tx_idx_q, rx_bit_q, rx_idx_q;
   logic [7:0] pkt_q [smpm_pkg::PAYLOAD_BYTES];
   logic sending, tx_tick, tx_byte_end, stat_meta_q, stat_q;
   logic rf_meta_q, rf_q, rf_prev_q, rx_samp, rx_en;

   // ==========================================
   // Transmit path: host UART into FIFO; FIFO runs during warm-up
   smpm_uart_rx #(.BIT_CYC(UART_BIT_CYC)) u_hrx (
      .clock_i(clock_i), .resetn_i(resetn_i), .line_i(link.txd),
      .data_o(hrx_data), .valid_o(hrx_valid));
   // Host is never throttled; a full FIFO drops the newest byte
   smpm_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txf (
      .clock_i(clock_i), .resetn_i(resetn_i),
      .wdata_i(hrx_data), .wvalid_i(hrx_valid), .wready_o(),
      .rdata_o(txf_rdata), .rvalid_o(txf_rvalid), .rready_i(txf_pop));

   // Byte boundary strobes of the radio serializer
   assign sending = tx_st_q inside {smpm_pkg::T_PRE, smpm_pkg::T_SYNC,
                                    smpm_pkg::T_PAY, smpm_pkg::T_SUM};
   assign tx_tick = sending && (tx_cnt_q == 0);
   assign tx_byte_end = tx_tick && (tx_bit_q == 3'h7);
   assign pay_byte = txf_rvalid ? txf_rdata : smpm_pkg::IDLE_CODE;
   assign txf_pop = tx_byte_end && ((tx_st_q == smpm_pkg::T_SYNC) ||
                    (tx_st_q == smpm_pkg::T_PAY && tx_idx_q != smpm_pkg::PAY_LAST));
   assign rf_tx_data_o = tx_sh_q[7];
   assign rf_tx_key_o = tx_st_q != smpm_pkg::T_OFF;
   assign link.status_dev_o = 1'b0;
   assign link.status_dev_oe_n = !sending;

   // Packet framer; no enable pin, data alone keys the radio
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_st_q <= smpm_pkg::T_OFF;
         tx_cnt_q <= '0;
         tx_sh_q <= '0;
         tx_bit_q <= '0;
         tx_idx_q <= '0;
         tx_sum_q <= '0;
      end else begin
         case (tx_st_q)
            smpm_pkg::T_OFF: if (txf_rvalid) begin
               tx_st_q <= smpm_pkg::T_WARM;
               tx_cnt_q <= STARTUP_CYC - 1;
            end
            smpm_pkg::T_WARM: if (tx_cnt_q != 0) begin
               tx_cnt_q <= tx_cnt_q - 1;
            end else begin
               tx_st_q <= smpm_pkg::T_PRE;
               tx_sh_q <= smpm_pkg::PREAMBLE_CODE;
               tx_idx_q <= '0;
               tx_bit_q <= '0;
               tx_cnt_q <= RF_BIT_CYC - 1;
            end
            default: if (tx_cnt_q != 0) begin
               tx_cnt_q <= tx_cnt_q - 1;
            end else begin
               tx_cnt_q <= RF_BIT_CYC - 1;
               tx_bit_q <= tx_bit_q + 3'h1;
               tx_sh_q <= {tx_sh_q[6:0], 1'b0};
               if (tx_bit_q == 3'h7) begin
                  case (tx_st_q)
                     smpm_pkg::T_PRE: if (tx_idx_q == smpm_pkg::PRE_LAST) begin
                        tx_st_q <= smpm_pkg::T_SYNC;
                        tx_sh_q <= smpm_pkg::SYNC_CODE;
                     end else begin
                        tx_idx_q <= tx_idx_q + 3'h1;
                        tx_sh_q <= smpm_pkg::PREAMBLE_CODE;
                     end
                     smpm_pkg::T_SYNC: begin
                        tx_st_q <= smpm_pkg::T_PAY;
                        tx_sh_q <= pay_byte;
                        tx_sum_q <= pay_byte;
                        tx_idx_q <= '0;
                     end
                     smpm_pkg::T_PAY: if (tx_idx_q == smpm_pkg::PAY_LAST) begin
                        tx_st_q <= smpm_pkg::T_SUM;
                        tx_sh_q <= tx_sum_q;
                     end else begin
                        tx_sh_q <= pay_byte;
                        tx_sum_q <= tx_sum_q + pay_byte;
                        tx_idx_q <= tx_idx_q + 3'h1;
                     end
                     smpm_pkg::T_SUM: if (txf_rvalid) begin
                        tx_st_q <= smpm_pkg::T_PRE;
                        tx_sh_q <= smpm_pkg::PREAMBLE_CODE;
                        tx_idx_q <= '0;
                     end else begin
                        tx_st_q <= smpm_pkg::T_OFF;
                        tx_sh_q <= '0;
                     end
                     default: tx_st_q <= smpm_pkg::T_OFF;
                  endcase
               end
            end
         endcase
      end
   end

   // ==========================================
   // Receive path: synchronisers for status pin and radio bits
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stat_meta_q <= 1'b1;
         stat_q <= 1'b1;
         rf_meta_q <= 1'b0;
         rf_q <= 1'b0;
      end else begin
         stat_meta_q <= link.status_level;
         stat_q <= stat_meta_q;
         rf_meta_q <= rf_rx_data_i;
         rf_q <= rf_meta_q;
      end
   end
   // Half duplex: listen only while keyed off and not held in standby
   assign rx_en = (tx_st_q == smpm_pkg::T_OFF) && stat_q;
   assign standby_o = (tx_st_q == smpm_pkg::T_OFF) && !stat_q;
   assign rx_samp = (rx_cnt_q == 0) && (rf_q == rf_prev_q);
   assign rx_bits = {rx_sh_q[6:0], rf_q};

   // Bit clock recovery: each edge re-centres the sample point
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rf_prev_q <= 1'b0;
         rx_cnt_q <= '0;
      end else begin
         rf_prev_q <= rf_q;
         if (rf_q != rf_prev_q) begin
            rx_cnt_q <= RF_BIT_CYC / 2;
         end else if (rx_cnt_q == 0) begin
            rx_cnt_q <= RF_BIT_CYC - 1;
         end else begin
            rx_cnt_q <= rx_cnt_q - 1;
         end
      end
   end

   // Deframer: hunt sync, collect payload and checksum, then unload
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_st_q <= smpm_pkg::R_HUNT;
         rx_sh_q <= '0;
         rx_bit_q <= '0;
         rx_idx_q <= '0;
         rx_sum_q <= '0;
      end else if (!rx_en) begin
         rx_st_q <= smpm_pkg::R_HUNT;
      end else begin
         case (rx_st_q)
            smpm_pkg::R_HUNT: if (rx_samp) begin
               rx_sh_q <= rx_bits;
               if (rx_bits == smpm_pkg::SYNC_CODE) begin
                  rx_st_q <= smpm_pkg::R_COLLECT;
                  rx_bit_q <= '0;
                  rx_idx_q <= '0;
               end
            end
            smpm_pkg::R_COLLECT: if (rx_samp) begin
               rx_sh_q <= rx_bits;
               rx_bit_q <= rx_bit_q + 3'h1;
               if (rx_bit_q == 3'h7) begin
                  if (rx_idx_q == smpm_pkg::CSUM_IDX) begin
                     rx_idx_q <= '0;
                     rx_st_q <= (rx_bits == rx_sum_q) ? smpm_pkg::R_PUSH
                                                      : smpm_pkg::R_HUNT;
                  end else begin
                     rx_sum_q <= (rx_idx_q == 3'h0) ? rx_bits : rx_sum_q + rx_bits;
                     rx_idx_q <= rx_idx_q + 3'h1;
                  end
               end
            end
            smpm_pkg::R_PUSH: begin
               rx_idx_q <= rx_idx_q + 3'h1;
               if (rx_idx_q == smpm_pkg::PAY_LAST) begin
                  rx_st_q <= smpm_pkg::R_HUNT;
               end
            end
            default: rx_st_q <= smpm_pkg::R_HUNT;
         endcase
      end
   end
   // Packet payload store
   always_ff @(posedge clock_i) begin
      if (rx_en && rx_st_q == smpm_pkg::R_COLLECT && rx_samp && rx_bit_q == 3'h7 &&
          rx_idx_q != smpm_pkg::CSUM_IDX) begin
         pkt_q[rx_idx_q] <= rx_bits;
      end
   end
   // Idle filler never reaches the host
   assign rxf_wvalid = (rx_st_q == smpm_pkg::R_PUSH) &&
                       (pkt_q[rx_idx_q] != smpm_pkg::IDLE_CODE);

   // Receive FIFO drains at the host baud rate; overflow drops
   smpm_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rxf (
      .clock_i(clock_i), .resetn_i(resetn_i),
      .wdata_i(pkt_q[rx_idx_q]), .wvalid_i(rxf_wvalid), .wready_o(),
      .rdata_o(rxf_rdata), .rvalid_o(rxf_rvalid), .rready_i(utx_ready));
   smpm_uart_tx #(.BIT_CYC(UART_BIT_CYC)) u_htx (
      .clock_i(clock_i), .resetn_i(resetn_i),
      .data_i(rxf_rdata), .valid_i(rxf_rvalid), .ready_o(utx_ready),
      .line_o(link.rxd));
endmodule

// >>> core/smpm_host.sv
// Purpose: host end: UART pair plus status pin handling
// Assumes: user logic runs on the same clock
// Notes: a two-entry buffer lets the user stall-free hand over bytes
`timescale 1ns/1ps
module smpm_host #(
   parameter int unsigned UART_BIT_CYC = smpm_pkg::UART_BIT_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Modem pins
   smpm_if.host link,
   // Bytes to send
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // Bytes received
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   // Status pin
   input wire logic standby_req_i,
   output logic remote_tx_o
);
   logic [7:0] buf_data;
   logic buf_valid, utx_ready, hold_q, lvl_meta_q, lvl_q;

   // ==========================================
   // Transmit: buffer absorbs UART busy time, user sees ready
   smpm_fifo #(.W(8), .DEPTH(smpm_pkg::SKID_DEPTH)) u_buf (
      .clock_i(clock_i), .resetn_i(resetn_i),
      .wdata_i(tx_data_i), .wvalid_i(tx_valid_i), .wready_o(tx_ready_o),
      .rdata_o(buf_data), .rvalid_o(buf_valid), .rready_i(utx_ready));
   // Line idles high between and without characters
   smpm_uart_tx #(.BIT_CYC(UART_BIT_CYC)) u_tx (
      .clock_i(clock_i), .resetn_i(resetn_i),
      .data_i(buf_data), .valid_i(buf_valid), .ready_o(utx_ready),
      .line_o(link.txd));

   // ==========================================
   // Receive: no flow control, every character is a pulse
   smpm_uart_rx #(.BIT_CYC(UART_BIT_CYC)) u_rx (
      .clock_i(clock_i), .resetn_i(resetn_i), .line_i(link.rxd),
      .data_o(rx_data_o), .valid_o(rx_valid_o));

   // ==========================================
   // Status: pull low for standby, otherwise watch for transmit
   assign link.status_host_o = 1'b0;
   assign link.status_host_oe_n = !hold_q;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hold_q <= 1'b0;
         lvl_meta_q <= 1'b1;
         lvl_q <= 1'b1;
         remote_tx_o <= 1'b0;
      end else begin
         hold_q <= standby_req_i;
         lvl_meta_q <= link.status_level;
         lvl_q <= lvl_meta_q;
         // Own pull-down masks the indicator
         remote_tx_o <= !lvl_q && !hold_q;
      end
   end
endmodule

// >>> verification/smpm_chk.sv
// Purpose: checks on the host-side pins of the modem pair
// Assumes: shortened bit counts handed in by the bench
// Notes: frame counters start on a fall from idle
`timescale 1ns/1ps
module smpm_chk #(
   parameter int unsigned BIT_CYC = 32,
   parameter int unsigned PKT_CYC = 1408
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Pins
   input wire logic txd_i,
   input wire logic rxd_i,
   input wire logic status_dev_oe_n_i,
   input wire logic status_level_i
);
   // ========
   // Frame position; a fall at frame end starts the next frame
   int unsigned rc_q;
   int unsigned tc_q;
   int unsigned lo_q;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) rc_q <= 0;
      else if (rc_q == 0 || rc_q == 10 * BIT_CYC) rc_q <= $fell(rxd_i) ? 1 : 0;
      else rc_q <= rc_q + 1;
   end
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) tc_q <= 0;
      else if (tc_q == 0 || tc_q == 10 * BIT_CYC) tc_q <= $fell(txd_i) ? 1 : 0;
      else tc_q <= tc_q + 1;
   end
   // Length of each low stretch of the transmit indicator
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) lo_q <= 0;
      else lo_q <= status_dev_oe_n_i ? 0 : lo_q + 1;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   property p_rst_idle; $rose(resetn_i) |-> txd_i && rxd_i && status_dev_oe_n_i; endproperty
   property p_rx_start; rc_q > 0 && rc_q < BIT_CYC |-> !rxd_i; endproperty
   property p_rx_edge; rc_q > 0 && rc_q % BIT_CYC != 0 |-> $stable(rxd_i); endproperty
   property p_rx_stop; rc_q > 9 * BIT_CYC && rc_q < 10 * BIT_CYC |-> rxd_i; endproperty
   property p_tx_start; tc_q > 0 && tc_q < BIT_CYC |-> !txd_i; endproperty
   property p_tx_edge; tc_q > 0 && tc_q % BIT_CYC != 0 |-> $stable(txd_i); endproperty
   property p_tx_stop; tc_q > 9 * BIT_CYC && tc_q < 10 * BIT_CYC |-> txd_i; endproperty
   // Two cycles of slack for where the indicator edge lands
   property p_pkt_whole; $rose(status_dev_oe_n_i) |-> lo_q + 2 >= PKT_CYC; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("lines not idle after reset");
   a_rx_start: assert property (p_rx_start) else $error("rxd start bit short");
   a_rx_edge: assert property (p_rx_edge) else $error("rxd moved inside a bit");
   a_rx_stop: assert property (p_rx_stop) else $error("rxd stop bit low");
   a_tx_start: assert property (p_tx_start) else $error("txd start bit short");
   a_tx_edge: assert property (p_tx_edge) else $error("txd moved inside a bit");
   a_tx_stop: assert property (p_tx_stop) else $error("txd stop bit low");
   a_pkt_whole: assert property (p_pkt_whole) else $error("indicator shorter than packet");
   c_rx_frame: cover property (rc_q == 9 * BIT_CYC + BIT_CYC / 2);
   c_tx_frame: cover property (tc_q == 9 * BIT_CYC + BIT_CYC / 2);
   c_pkt: cover property ($rose(status_dev_oe_n_i));
   c_standby: cover property (!status_level_i && status_dev_oe_n_i);
endmodule

// >>> verification/smpm_bench.sv
// Purpose: host end and modem end joined across the pin interface
// Assumes: shortened UART, radio and warm-up counts
// Notes: radio input driven here, radio output sampled mid-bit
`timescale 1ns/1ps
module smpm_bench;
   localparam int unsigned UB = 32;
   localparam int unsigned RB = 16;
   logic clock_i = 0;
   logic resetn_i = 0;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 0;
   logic sb_req = 0;
   logic rf_in = 0;
   logic rf_out, rf_key, standby, tx_ready, rx_valid, remote;
   logic [7:0] rx_data;
   int err_count = 0;
   int comparisons = 0;
   smpm_if link_if ();
   smpm_device #(.UART_BIT_CYC(UB), .RF_BIT_CYC(RB), .STARTUP_CYC(600), .FIFO_DEPTH(32))
      smpm_device_inst (.clock_i, .resetn_i, .link(link_if.device), .rf_tx_data_o(rf_out),
      .rf_tx_key_o(rf_key), .rf_rx_data_i(rf_in), .standby_o(standby));
   smpm_host #(.UART_BIT_CYC(UB)) smpm_host_inst (.clock_i, .resetn_i, .link(link_if.host),
      .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
      .rx_valid_o(rx_valid), .standby_req_i(sb_req), .remote_tx_o(remote));
   smpm_chk #(.BIT_CYC(UB), .PKT_CYC(88 * RB)) smpm_chk_inst (.clock_i, .resetn_i,
      .txd_i(link_if.txd), .rxd_i(link_if.rxd),
      .status_dev_oe_n_i(link_if.status_dev_oe_n), .status_level_i(link_if.status_level));
   // ========
   // Clock, 4 ns period
   always #2 clock_i = ~clock_i;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hold valid until an edge sees ready
   task automatic send_host(input logic [7:0] b);
      @(negedge clock_i);
      tx_data = b;
      tx_valid = 1;
      do @(posedge clock_i); while (tx_ready !== 1'b1);
      @(negedge clock_i);
      tx_valid = 0;
   endtask
   // Radio bytes MSB first, one bit each RB cycles
   task automatic rf_pkt(input logic [7:0] s, p1, p2, cs);
      logic [7:0] q [11];
      q = '{8'h55, 8'h55, 8'h55, s, p1, 8'h00, p2, 8'h00, 8'h00, 8'h00, cs};
      // Half duplex: the far modem only talks while ours is keyed off
      check({7'h00, rf_key}, 8'h00);
      for (int k = 0; k < 88; k++) begin
         @(negedge clock_i);
         rf_in = q[k / 8][7 - k % 8];
         repeat (RB - 1) @(negedge clock_i);
      end
   endtask
   task automatic grab(input logic [7:0] want [11]);
      logic [7:0] b;
      for (int i = 0; i < 20000 && link_if.status_dev_oe_n !== 1'b0; i++) @(posedge clock_i);
      check({7'h00, rf_key}, 8'h01);
      repeat (RB / 2) @(posedge clock_i);
      for (int k = 0; k < 11; k++) begin
         for (int j = 0; j < 8; j++) begin
            b = {b[6:0], rf_out};
            repeat (RB) @(posedge clock_i);
         end
         check(b, want[k]);
         if (k == 5) check({7'h00, remote}, {7'h00, !sb_req});
      end
   endtask
   // A one-cycle pulse is looked at just after each edge
   task automatic expect_rx(input logic [7:0] want, input logic hit);
      logic seen;
      seen = 0;
      for (int i = 0; i < 3000 && !seen; i++) begin
         @(posedge clock_i);
         #1 seen = (rx_valid === 1'b1);
      end
      check({7'h00, seen}, {7'h00, hit});
      if (hit) check(rx_data, want);
   endtask
   task automatic t_tx();
      send_host(8'h12);
      send_host(8'h34);
      check({7'h00, tx_ready}, 8'h01);
      grab('{8'h55, 8'h55, 8'h55, 8'hb4, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h00, 8'h46});
      repeat (RB) @(posedge clock_i);
      check({7'h00, rf_key}, 8'h00);
      $display("test tx done");
   endtask
   task automatic t_rx();
      check({7'h00, standby}, 8'h00);
      rf_pkt(8'hb4, 8'h41, 8'h42, 8'h83);
      expect_rx(8'h41, 1'b1);
      expect_rx(8'h42, 1'b1);
      rf_pkt(8'hb4, 8'h43, 8'h00, 8'h00);
      expect_rx(8'h00, 1'b0);
      rf_pkt(8'h00, 8'h44, 8'h00, 8'h44);
      expect_rx(8'h00, 1'b0);
      $display("test rx done");
   endtask
   task automatic t_sb();
      @(negedge clock_i);
      sb_req = 1;
      repeat (8) @(negedge clock_i);
      check({7'h00, standby}, 8'h01);
      check({7'h00, link_if.status_level}, 8'h00);
      rf_pkt(8'hb4, 8'h45, 8'h00, 8'h45);
      expect_rx(8'h00, 1'b0);
      send_host(8'h5a);
      grab('{8'h55, 8'h55, 8'h55, 8'hb4, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a});
      @(negedge clock_i);
      sb_req = 0;
      $display("test standby done");
   endtask
   // Reset two cycles, then the tests in turn
   initial begin
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      resetn_i = 1;
      t_tx();
      t_rx();
      t_sb();
      summarize();
   end
   // Watchdog well beyond the expected run of some 20000 cycles
   initial begin
      repeat (60000) @(posedge clock_i);
      err_count++;
      summarize();
   end
endmodule
